// ===== include/aclink_pkg.sv
// Constants and types of the serial codec link controller
// Contract
// - Audio and modem functions accept only full-on and hot-off power states.
// - In the off state the interrupt never asserts; wake goes to the wake request.
// - Power state written from hot-off to full-on resets that function.
// - Wake status sets only on a resume event or modem input change with its wake enable set.
// - Modem input change causes a wake event only while modem is off.
// - Input-line resume sets its interrupt status only while its function is on.
// - Resume detection is edge based, so a held level raises nothing later.
// - A status bit drives the shared interrupt only when its enable is set.
// - Each frame carries twelve outgoing and twelve incoming slots, three codecs.
// - Outputs change on rising bit-clock edges; inputs sample on falling edges.
// - Five clocks without bit-clock transition set global status bit 28.
// - While clock is missing codec accesses complete at once reading all ones.
// - Frame sync divides the bit clock, high for 16 bit clocks each frame.
// - Shutdown turns off all link output drivers.
// - Three input lines carry traffic alike; interrupt status per line, one shared wake status.
// - Slot 0 first bit goes out one rising edge after sync rises.
// - Slots go out MSB first, unused bits and invalid slots as zeros.
// - Slot 0 is a 16-bit tag; untagged slots are all zeros.
// - Tag bit 15 marks the frame valid when any slot is valid.
// - After a control slot 12 write that slot stays valid every frame until a modem reset.
// - Tag bits 14:3 mark slots 1 to 12; bits 1:0 carry codec id.
// - Codec requests output slots with active-low bits in input slot 1.
package aclink_pkg;
  localparam int FRAME_BITS = 256;
  localparam int TAG_BITS = 16;
  localparam int SLOT_BITS = 20;
  localparam int SYNC_BITS = 16;
  localparam int LINES = 3;
  localparam logic [2:0] MISSING_CLOCKS = 3'h4;
  localparam logic [7:0] LAST_POS = 8'hFF;
  localparam logic [7:0] SLOT1_END = 8'h23;
  localparam logic [7:0] SLOT2_END = 8'h37;
  localparam int REQ_SLOT3_BIT = 11;
  localparam int REQ_SLOT4_BIT = 10;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PM_OFS = 8'h04;
  localparam logic [7:0] INTSTS_OFS = 8'h08;
  localparam logic [7:0] INTEN_OFS = 8'h0C;
  localparam logic [7:0] GPIO_OFS = 8'h10;
  localparam logic [7:0] CODEC_OFS = 8'h14;
  localparam logic [7:0] PCML_OFS = 8'h18;
  localparam logic [7:0] PCMR_OFS = 8'h1C;
  localparam logic [7:0] GSTAT_OFS = 8'h30;
  localparam int GSTAT_MISSING_BIT = 28;
  localparam int PM_WAKE_STS_BIT = 16;
  localparam int PM_AWAKE_EN_BIT = 8;
  localparam int PM_MWAKE_EN_BIT = 9;
  localparam int CODEC_READ_BIT = 23;
  localparam logic [1:0] PS_ON = 2'h0;
  localparam logic [1:0] PS_OFF = 2'h3;
  localparam logic [3:0] MODEM_BITS = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;

  typedef struct packed {
    logic frameSync;
    logic frameSyncOe;
    logic serialDataOut;
    logic serialDataOutOe;
    logic linkReset_n;
    logic linkResetOe;
  } linkOut_type;
endpackage

// ===== verilog/audio_codec_link_controller.sv
// Serial codec link controller with power and wake logic
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module audio_codec_link_controller
  import aclink_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link pins
  input wire logic serialBitClock,
  input wire logic [LINES-1:0] serialDataIn,
  output linkOut_type linkOut,
  // System signals
  output logic sharedIrqLineB_n,
  output logic powerWakeRequest_n
);

  typedef struct packed {
    logic [2:0] bclkSync;
    logic bclkLvl;
    logic [LINES-1:0][2:0] sdinSync;
    logic [LINES-1:0] sdinLvl;
    logic [2:0] idleCnt;
    logic missing;
    logic [7:0] bitCnt;
    logic sync;
    logic sdout;
    logic [FRAME_BITS-1:0] frame;
    logic [SLOT_BITS-1:0] inShift;
    logic [1:0] slot_request_bits;
    logic [15:0] gpioIn;
    logic [15:0] codecData;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic linkRelease;
    logic shutdown;
    logic [1:0] codecId;
    logic [1:0] audioPs;
    logic [1:0] modemPs;
    logic audioWakeEn;
    logic modemWakeEn;
    logic wakeSts;
    logic [3:0] intSts;
    logic [3:0] intEn;
    logic slot12Valid;
    logic [15:0] gpioOut;
    logic cmdPending;
    logic [23:0] cmdWord;
    logic [19:0] sampleLeft;
    logic [19:0] sampleRight;
    logic samplePending;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (val & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state
  logic bRise;
  logic bFall;
  logic [LINES-1:0] resumeEv;
  logic gpioChange;
  logic linkDown;
  logic inBit;
  logic [7:0] inPos;
  logic [SLOT_BITS-1:0] inWord;
  logic sendCmd;
  logic sendSample;
  logic [TAG_BITS-1:0] tag;
  logic [3:0] setSts;
  logic wrDo;
  logic [31:0] wv;
  logic [31:0] wr;
  logic [31:0] pmOld;
  logic [1:0] newAps;
  logic [1:0] newMps;
  logic audioReset;
  logic modemReset;
  logic wakeSet;

  always_comb
  begin
    st_nxt = st_r;
    bRise = 1'b0;
    bFall = 1'b0;
    resumeEv = '0;
    gpioChange = 1'b0;
    inWord = '0;
    sendCmd = 1'b0;
    sendSample = 1'b0;
    tag = '0;
    wv = '0;
    wr = '0;
    pmOld = '0;
    newAps = st_r.audioPs;
    newMps = st_r.modemPs;
    audioReset = 1'b0;
    modemReset = 1'b0;
    linkDown = !st_r.linkRelease || st_r.shutdown;
    inBit = |st_r.sdinLvl;
    inPos = st_r.bitCnt - 8'h01;

    // Pin synchronisers, a change counts once stages two and three agree
    st_nxt.bclkSync = {st_r.bclkSync[1:0], serialBitClock};
    if (st_r.bclkSync[2] == st_r.bclkSync[1])
    begin
      st_nxt.bclkLvl = st_r.bclkSync[2];
      bRise = st_r.bclkSync[2] && !st_r.bclkLvl;
      bFall = !st_r.bclkSync[2] && st_r.bclkLvl;
    end
    for (int i = 0; i < LINES; i++)
    begin
      st_nxt.sdinSync[i] = {st_r.sdinSync[i][1:0], serialDataIn[i]};
      if (st_r.sdinSync[i][2] == st_r.sdinSync[i][1])
      begin
        st_nxt.sdinLvl[i] = st_r.sdinSync[i][2];
        resumeEv[i] = linkDown && st_r.sdinSync[i][2] && !st_r.sdinLvl[i];
      end
    end

    // Missing bit clock watchdog
    if (bRise || bFall)
    begin
      st_nxt.idleCnt = '0;
      st_nxt.missing = 1'b0;
    end
    else if (st_r.idleCnt != MISSING_CLOCKS)
      st_nxt.idleCnt = st_r.idleCnt + 3'h1;
    else
      st_nxt.missing = 1'b1;

    // Output frame, changed on rising edges
    sendCmd = st_r.cmdPending;
    sendSample = st_r.samplePending && (&st_r.slot_request_bits);
    tag[15 - 1] = sendCmd;
    tag[15 - 2] = sendCmd;
    tag[15 - 3] = sendSample;
    tag[15 - 4] = sendSample;
    tag[15 - 12] = st_r.slot12Valid;
    tag[1:0] = st_r.codecId;
    tag[15] = |tag[14:3];
    if (bRise && !linkDown)
    begin
      st_nxt.bitCnt = st_r.bitCnt + 8'h01;
      st_nxt.sync = (st_nxt.bitCnt < 8'(SYNC_BITS));
      st_nxt.sdout = st_r.frame[FRAME_BITS-1];
      st_nxt.frame = {st_r.frame[FRAME_BITS-2:0], 1'b0};
      if (st_r.bitCnt == LAST_POS)
      begin
        st_nxt.frame = {tag,
          sendCmd ? {st_r.cmdWord[CODEC_READ_BIT], st_r.cmdWord[22:16], 12'h000} : 20'h00000,
          (sendCmd && !st_r.cmdWord[CODEC_READ_BIT]) ? {st_r.cmdWord[15:0], 4'h0} : 20'h00000,
          sendSample ? st_r.sampleLeft : 20'h00000,
          sendSample ? st_r.sampleRight : 20'h00000,
          140'h0,
          st_r.slot12Valid ? {st_r.gpioOut, 4'h0} : 20'h00000};
        st_nxt.cmdPending = 1'b0;
        if (sendSample)
          st_nxt.samplePending = 1'b0;
      end
    end
    else if (linkDown)
    begin
      st_nxt.bitCnt = LAST_POS;
      st_nxt.sync = 1'b0;
      st_nxt.sdout = 1'b0;
    end

    // Input frame, sampled on falling edges
    if (bFall && !linkDown)
    begin
      inWord = {st_r.inShift[SLOT_BITS-2:0], inBit};
      st_nxt.inShift = inWord;
      if (inPos == SLOT1_END)
        st_nxt.slot_request_bits = {~inWord[REQ_SLOT3_BIT], ~inWord[REQ_SLOT4_BIT]};
      if (inPos == SLOT2_END)
        st_nxt.codecData = inWord[19:4];
      if (inPos == LAST_POS)
      begin
        st_nxt.gpioIn = inWord[19:4];
        gpioChange = (inWord[19:4] != st_r.gpioIn);
      end
    end

    // Event status
    setSts[0] = resumeEv[0] && st_r.audioPs != PS_OFF;
    setSts[1] = resumeEv[1] && st_r.modemPs != PS_OFF;
    setSts[2] = resumeEv[2] && st_r.audioPs != PS_OFF;
    setSts[3] = gpioChange && st_r.modemPs != PS_OFF;
    wakeSet = ((resumeEv[0] || resumeEv[2]) && st_r.audioWakeEn) ||
              (resumeEv[1] && st_r.modemWakeEn) ||
              (gpioChange && st_r.modemPs == PS_OFF && st_r.modemWakeEn);

    // Write channel
    if (awvalid && awready)
    begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = wdata;
      st_nxt.wStrb = wstrb;
    end
    wrDo = st_r.awHeld && st_r.wHeld && !st_r.bvalid;
    if (wrDo)
    begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      wv = st_r.wData & merge('0, ALL_ONES, st_r.wStrb);
      case (st_r.awAddr)
        CTRL_OFS:
        begin
          wr = merge({26'h0, st_r.codecId, 2'h0, st_r.shutdown, st_r.linkRelease}, st_r.wData, st_r.wStrb);
          st_nxt.linkRelease = wr[0];
          st_nxt.shutdown = wr[1];
          st_nxt.codecId = wr[5:4];
        end
        PM_OFS:
        begin
          pmOld = {22'h0, st_r.modemWakeEn, st_r.audioWakeEn, 4'h0, st_r.modemPs, st_r.audioPs};
          wr = merge(pmOld, st_r.wData, st_r.wStrb);
          if (wr[1:0] == PS_ON || wr[1:0] == PS_OFF)
            newAps = wr[1:0];
          if (wr[3:2] == PS_ON || wr[3:2] == PS_OFF)
            newMps = wr[3:2];
          audioReset = st_r.audioPs == PS_OFF && newAps == PS_ON;
          modemReset = st_r.modemPs == PS_OFF && newMps == PS_ON;
          st_nxt.audioPs = newAps;
          st_nxt.modemPs = newMps;
          st_nxt.audioWakeEn = wr[PM_AWAKE_EN_BIT];
          st_nxt.modemWakeEn = wr[PM_MWAKE_EN_BIT];
          if (wv[PM_WAKE_STS_BIT])
            st_nxt.wakeSts = 1'b0;
        end
        INTSTS_OFS:
          st_nxt.intSts = st_r.intSts & ~wv[3:0];
        INTEN_OFS:
        begin
          wr = merge({28'h0, st_r.intEn}, st_r.wData, st_r.wStrb);
          st_nxt.intEn = wr[3:0];
        end
        GPIO_OFS:
        begin
          wr = merge({16'h0, st_r.gpioOut}, st_r.wData, st_r.wStrb);
          st_nxt.gpioOut = wr[15:0];
          st_nxt.slot12Valid = 1'b1;
        end
        CODEC_OFS:
          if (!st_r.missing)
          begin
            wr = merge({8'h0, st_r.cmdWord}, st_r.wData, st_r.wStrb);
            st_nxt.cmdWord = wr[23:0];
            st_nxt.cmdPending = 1'b1;
          end
        PCML_OFS:
        begin
          wr = merge({12'h0, st_r.sampleLeft}, st_r.wData, st_r.wStrb);
          st_nxt.sampleLeft = wr[19:0];
        end
        PCMR_OFS:
        begin
          wr = merge({12'h0, st_r.sampleRight}, st_r.wData, st_r.wStrb);
          st_nxt.sampleRight = wr[19:0];
          st_nxt.samplePending = 1'b1;
        end
        GSTAT_OFS:
          st_nxt.bresp = RESP_OKAY;
        default:
          st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && bready)
      st_nxt.bvalid = 1'b0;

    // Sticky status, a set wins over a clear
    st_nxt.intSts = st_nxt.intSts | setSts;
    st_nxt.wakeSts = st_nxt.wakeSts || wakeSet;
    if (audioReset)
    begin
      st_nxt.intSts = st_nxt.intSts & MODEM_BITS;
      st_nxt.intEn = st_nxt.intEn & MODEM_BITS;
      st_nxt.samplePending = 1'b0;
    end
    if (modemReset)
    begin
      st_nxt.intSts = st_nxt.intSts & ~MODEM_BITS;
      st_nxt.intEn = st_nxt.intEn & ~MODEM_BITS;
      st_nxt.slot12Valid = 1'b0;
      st_nxt.gpioOut = '0;
    end

    // Read channel
    if (arvalid && arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (araddr)
        CTRL_OFS:
          st_nxt.rdata = {26'h0, st_r.codecId, 2'h0, st_r.shutdown, st_r.linkRelease};
        PM_OFS:
          st_nxt.rdata = {15'h0, st_r.wakeSts, 6'h0, st_r.modemWakeEn, st_r.audioWakeEn, 4'h0,
                          st_r.modemPs, st_r.audioPs};
        INTSTS_OFS:
          st_nxt.rdata = {28'h0, st_r.intSts};
        INTEN_OFS:
          st_nxt.rdata = {28'h0, st_r.intEn};
        GPIO_OFS:
          st_nxt.rdata = {st_r.gpioIn, st_r.gpioOut};
        CODEC_OFS:
          st_nxt.rdata = st_r.missing ? ALL_ONES : {st_r.cmdPending, 15'h0, st_r.codecData};
        PCML_OFS:
          st_nxt.rdata = {12'h0, st_r.sampleLeft};
        PCMR_OFS:
          st_nxt.rdata = {12'h0, st_r.sampleRight};
        GSTAT_OFS:
        begin
          st_nxt.rdata = {3'h0, st_r.missing, 22'h0, st_r.slot_request_bits, st_r.samplePending, st_r.sdinLvl};
          st_nxt.rdata[GSTAT_MISSING_BIT] = st_r.missing;
        end
        default:
        begin
          st_nxt.rdata = '0;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (st_r.rvalid && rready)
      st_nxt.rvalid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.bitCnt <= LAST_POS;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign awready = !st_r.awHeld && !st_r.bvalid;
  assign wready = !st_r.wHeld && !st_r.bvalid;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = !st_r.rvalid;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  assign linkOut.frameSync = st_r.sync;
  assign linkOut.serialDataOut = st_r.sdout;
  assign linkOut.linkReset_n = st_r.linkRelease;
  assign linkOut.frameSyncOe = !st_r.shutdown;
  assign linkOut.serialDataOutOe = !st_r.shutdown;
  assign linkOut.linkResetOe = !st_r.shutdown;

  assign sharedIrqLineB_n = !(|(st_r.intSts & st_r.intEn &
    ~((st_r.audioPs == PS_OFF) ? ~MODEM_BITS : 4'h0) &
    ~((st_r.modemPs == PS_OFF) ? MODEM_BITS : 4'h0)));
  assign powerWakeRequest_n = !st_r.wakeSts;

endmodule
`default_nettype wire

// ===== bench/aclink_checker.sv
// Port assertions for the serial codec link controller
`timescale 1ns/1ps
`default_nettype none
module aclink_checker
  import aclink_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  // Link and system
  input wire logic serialBitClock,
  input wire linkOut_type linkOut,
  input wire logic sharedIrqLineB_n,
  input wire logic powerWakeRequest_n
);
  logic [7:0] wAddr_r, rAddr_r;
  logic [31:0] wData_r, pm_r, intEn_r;
  logic [8:0] bitCnt_r;
  logic [4:0] still_r;
  logic clkDly_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // Shadow of written registers and bit clock counters
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wAddr_r <= 8'h00;
      rAddr_r <= 8'h00;
      wData_r <= 32'h0;
      pm_r <= 32'h0;
      intEn_r <= 32'h0;
      bitCnt_r <= 9'h1FF;
      still_r <= 5'h00;
      clkDly_r <= 1'b0;
    end
    else
    begin
      clkDly_r <= serialBitClock;
      if (awvalid && awready) wAddr_r <= awaddr;
      if (wvalid && wready) wData_r <= wdata;
      if (arvalid && arready) rAddr_r <= araddr;
      if (bvalid && bready && wAddr_r == PM_OFS) pm_r <= wData_r;
      if (bvalid && bready && wAddr_r == INTEN_OFS) intEn_r <= wData_r;
      if ($rose(linkOut.frameSync)) bitCnt_r <= 9'h000;
      else if (serialBitClock && !clkDly_r && bitCnt_r != 9'h1FF) bitCnt_r <= bitCnt_r + 9'h001;
      if (serialBitClock != clkDly_r) still_r <= 5'h00;
      else if (still_r != 5'h1F) still_r <= still_r + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Sequences
  sequence readOf(logic [7:0] a);
    rvalid && rAddr_r == a;
  endsequence
  sequence clockStill;
    still_r >= 5'h10;
  endsequence
  ////////////////////////////////////////////////////////////////
  // Assertions
  chk_sync_width: assert property (
    $fell(linkOut.frameSync) && linkOut.frameSyncOe |-> bitCnt_r == 9'h010)
    else $error("Frame sync width wrong");
  chk_frame_length: assert property (
    $rose(linkOut.frameSync) && bitCnt_r != 9'h1FF |-> bitCnt_r == 9'h100)
    else $error("Frame length wrong");
  chk_out_edge: assert property (
    $changed(linkOut.serialDataOut) && linkOut.serialDataOutOe && $past(linkOut.serialDataOutOe)
    |-> $past(serialBitClock, 3)) else $error("Data out changed off rising edge");
  chk_missing_flag: assert property (
    readOf(GSTAT_OFS) ##0 clockStill |-> rdata[GSTAT_MISSING_BIT])
    else $error("Missing clock flag not set");
  chk_missing_data: assert property (
    readOf(CODEC_OFS) ##0 clockStill |-> rdata == ALL_ONES)
    else $error("Codec read not all ones");
  chk_irq_off: assert property (
    !bvalid && pm_r[1:0] == PS_OFF && pm_r[3:2] == PS_OFF |-> sharedIrqLineB_n)
    else $error("Interrupt while functions off");
  chk_irq_mask: assert property (
    !bvalid && intEn_r[3:0] == 4'h0 |-> sharedIrqLineB_n)
    else $error("Interrupt with no enable");
  chk_wake_enable: assert property (
    $fell(powerWakeRequest_n) |-> pm_r[PM_AWAKE_EN_BIT] || pm_r[PM_MWAKE_EN_BIT])
    else $error("Wake without enable");
  chk_read_answer: assert property (
    arvalid && arready |=> rvalid) else $error("Read answer late");
endmodule
bind audio_codec_link_controller aclink_checker checker_i (.clock(clock), .nrst(nrst),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .serialBitClock(serialBitClock),
  .linkOut(linkOut), .sharedIrqLineB_n(sharedIrqLineB_n), .powerWakeRequest_n(powerWakeRequest_n));
`default_nettype wire

// ===== bench/codec_model.sv
// Behavioural codec: bit clock source, frame capture, slot requests
`timescale 1ns/1ps
`default_nettype none
module codec_model
  import aclink_pkg::*;
#(
  parameter int HALF_NS = 200
)
(
  // Bench controls
  input wire logic run,
  input wire logic [1:0] slot_request_bits,
  input wire logic [LINES-1:0] wake,
  // Link pins
  input wire linkOut_type linkOut,
  output logic serialBitClock,
  output logic [LINES-1:0] serialDataIn,
  // Captured output frame
  output logic [FRAME_BITS-1:0] lastFrame,
  output logic [7:0] frameCnt
);
  logic [FRAME_BITS-1:0] shift;
  logic syncSeen;
  logic dataBit;
  int pos;
  initial
  begin
    serialBitClock = 1'b0;
    shift = '0;
    lastFrame = '0;
    frameCnt = 8'h00;
    syncSeen = 1'b0;
    dataBit = 1'b0;
    pos = 0;
  end
  // Bit clock, rests low when stopped
  always
  begin
    #HALF_NS;
    if (run || serialBitClock)
      serialBitClock = !serialBitClock;
  end
  // Undriven lines rest at the pull-down level
  assign serialDataIn = wake | {2'b00, dataBit && linkOut.linkReset_n && run};
  always @(negedge serialBitClock)
  begin
    shift = {shift[FRAME_BITS-2:0], linkOut.serialDataOut};
    if (linkOut.frameSync && !syncSeen)
    begin
      lastFrame = shift;
      frameCnt = frameCnt + 8'h01;
      pos = 0;
    end
    syncSeen = linkOut.frameSync;
  end
  // Ready, slots 1 and 2 valid, active-low requests for slots 3 and 4
  always @(posedge serialBitClock)
  begin
    dataBit = pos < 3 || (pos == 24 && !slot_request_bits[1]) || (pos == 25 && !slot_request_bits[0]);
    pos = pos + 1;
  end
endmodule
`default_nettype wire

// ===== bench/audio_codec_link_controller_tb.sv
// Testbench of the serial codec link controller
`timescale 1ns/1ps
`default_nettype none
module audio_codec_link_controller_tb
  import aclink_pkg::*;
;
  logic clock, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, frameCnt;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, slot_request_bits;
  logic [2:0] wake, serialDataIn;
  logic serialBitClock, sharedIrqLineB_n, powerWakeRequest_n, run;
  logic [255:0] lastFrame;
  logic [19:0] got;
  linkOut_type linkOut;
  int failCount, nChecks, hits;
  audio_codec_link_controller dut (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .serialBitClock(serialBitClock),
    .serialDataIn(serialDataIn), .linkOut(linkOut), .sharedIrqLineB_n(sharedIrqLineB_n),
    .powerWakeRequest_n(powerWakeRequest_n));
  codec_model codec (.run(run), .slot_request_bits(slot_request_bits), .wake(wake), .linkOut(linkOut),
    .serialBitClock(serialBitClock), .serialDataIn(serialDataIn), .lastFrame(lastFrame), .frameCnt(frameCnt));
  ////////////////////////////////////////////////////////////////
  // Tasks
  always #20 clock = !clock;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic printVerdict();
    $display("Checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic aTake, wTake, done;
    done = 1'b0;
    @(posedge clock);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(negedge clock);
      aTake = awvalid && awready;
      wTake = wvalid && wready;
      done = bvalid;
      rr = bresp;
      @(posedge clock);
      if (aTake) awvalid <= 1'b0;
      if (wTake) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    if (!done) failCount++;
    check("write resp", 32'(rr), 32'(RESP_OKAY));
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic aTake, done;
    done = 1'b0;
    {d, r} = '1;
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(negedge clock);
      aTake = arvalid && arready;
      done = rvalid;
      if (done) {d, r} = {rdata, rresp};
      @(posedge clock);
      if (aTake) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) failCount++;
  endtask
  task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axiRead(a, rd, rr);
    check(name, rd & m, e);
  endtask
  // Counts frames whose tag bit is set and keeps one slot of the last such frame
  task automatic scan(input int n, input int idx, input int k);
    logic [7:0] f;
    hits = 0;
    repeat (n)
    begin
      f = frameCnt;
      for (int i = 0; i < 4000 && frameCnt === f; i++) @(posedge clock);
      if (frameCnt === f) failCount++;
      if (lastFrame[idx] === 1'b1) {hits, got} = {hits + 1, lastFrame[259-20*k -: 20]};
    end
  endtask
  task automatic settle();
    repeat (20) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    #3200000;
    failCount++;
    printVerdict();
  end
  initial
  begin
    {clock, nrst, awvalid, wvalid, bready, arvalid, rready, run} = '0;
    {awaddr, araddr, wdata, wstrb, slot_request_bits, wake} = {48'h0, 4'hF, 5'h00};
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rdChk("pm reset", PM_OFS, ALL_ONES, 32'h0);
    axiWrite(PM_OFS, 32'h00000001);
    rdChk("pm state 1", PM_OFS, 32'h0000000F, 32'h0);
    axiWrite(PM_OFS, 32'h00000008);
    rdChk("pm state 2", PM_OFS, 32'h0000000F, 32'h0);
    axiRead(8'h2C, rd, rr);
    check("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
    run <= 1'b1;
    axiWrite(CTRL_OFS, 32'h00000021);
    scan(2, 255, 1);
    check("idle tag", 32'(lastFrame[255:243]), 32'h0);
    check("link reset", 32'(linkOut.linkReset_n), 32'h1);
    axiWrite(GPIO_OFS, 32'h0000A5A5);
    scan(2, 243, 12);
    check("gpio tag", 32'(lastFrame[255:240]), 32'h0000800A);
    check("gpio slot", 32'(got), 32'h000A5A50);
    check("slot 5 empty", 32'(lastFrame[159:140]), 32'h0);
    axiWrite(PCML_OFS, 32'h00012345);
    axiWrite(PCMR_OFS, 32'h000ABCDE);
    scan(2, 252, 3);
    check("unrequested", 32'(hits), 32'h0);
    check("slot 3 empty", 32'(lastFrame[199:180]), 32'h0);
    rdChk("pending", GSTAT_OFS, 32'h00000038, 32'h00000008);
    slot_request_bits <= 2'b11;
    scan(4, 252, 3);
    check("sent once", 32'(hits), 32'h1);
    check("left sample", 32'(got), 32'h00012345);
    rdChk("requests", GSTAT_OFS, 32'h00000038, 32'h00000030);
    axiWrite(CODEC_OFS, 32'h0012BEEF);
    scan(3, 254, 2);
    check("cmd frames", 32'(hits), 32'h1);
    check("cmd data", 32'(got), 32'h000BEEF0);
    axiWrite(CTRL_OFS, 32'h00000023);
    run <= 1'b0;
    repeat (50) @(posedge clock);
    check("drivers off", 32'({linkOut.frameSyncOe, linkOut.serialDataOutOe, linkOut.linkResetOe}), 32'h0);
    rdChk("missing", GSTAT_OFS, 32'h10000000, 32'h10000000);
    rdChk("missing read", CODEC_OFS, ALL_ONES, ALL_ONES);
    axiWrite(PM_OFS, 32'h00000103);
    axiWrite(INTEN_OFS, 32'h0000000F);
    wake <= 3'b001;
    settle();
    check("wake pin", 32'(powerWakeRequest_n), 32'h0);
    check("irq off", 32'(sharedIrqLineB_n), 32'h1);
    rdChk("off status", INTSTS_OFS, 32'h0000000F, 32'h0);
    rdChk("wake status", PM_OFS, 32'h0001030F, 32'h00010103);
    axiWrite(PM_OFS, 32'h00010003);
    wake <= 3'b000;
    settle();
    wake <= 3'b001;
    settle();
    check("wake masked", 32'(powerWakeRequest_n), 32'h1);
    axiWrite(PM_OFS, 32'h00000000);
    rdChk("enables reset", INTEN_OFS, 32'h0000000F, 32'h0000000A);
    rdChk("no edge", INTSTS_OFS, 32'h0000000F, 32'h0);
    axiWrite(INTEN_OFS, 32'h00000005);
    wake <= 3'b000;
    settle();
    wake <= 3'b101;
    settle();
    rdChk("per line", INTSTS_OFS, 32'h0000000F, 32'h00000005);
    check("irq on", 32'(sharedIrqLineB_n), 32'h0);
    axiWrite(INTEN_OFS, 32'h00000000);
    check("irq masked", 32'(sharedIrqLineB_n), 32'h1);
    run <= 1'b1;
    settle();
    rdChk("clock back", GSTAT_OFS, 32'h10000000, 32'h0);
    printVerdict();
  end
endmodule
`default_nettype wire
